//--- rtl/dcibs_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "dcibs_consts.svh"

module dcibs_top
    import dcibs_pkg::*;
#(
    parameter int INIT_CYCLES = `DCIBS_INIT_CYCLES,
    parameter int QUAL_CYCLES = `DCIBS_QUAL_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Initialisation inputs
    input wire logic memSelfTestFail,
    input wire logic [7:0] chanABootStrapPin,
    input wire logic strapOverrideSetting,
    input wire logic [15:0] nonvolatileStoreVoutA,
    input wire logic [15:0] nonvolatileStoreVoutB,
    input wire logic [1:0] senseOpen,
    input wire logic [1:0] senseShort,
    // Channel inputs, index 0 is channel A
    input wire logic chanAEnablePin,
    input wire logic chanBEnablePin,
    input wire logic [1:0] stageInputAboveOn,
    input wire logic [1:0] driverSupplyLowFault,
    input wire logic [1:0] faultShutdown,
    input wire logic [1:0] avsVoutValid,
    input wire logic [1:0][15:0] avsVout,
    // Channel outputs
    output logic [1:0] pwmEnable,
    output logic [1:0] pwmOen,
    output logic chanAPowerGood,
    output logic chanBPowerGood,
    output logic [1:0][15:0] setpoint,
    output logic senseScaleEn,
    output logic initDone
);

    // ****************************************
    // Bus decode
    // ****************************************
    dcibs_state_s q;
    dcibs_state_s next_q;
    logic [1:0] enPin;
    logic [1:0] enCond;
    logic setupPh;
    logic wrAcc;
    logic [1:0] wrVout;
    logic usTick;
    logic [15:0] strapBoot;

    assign enPin = {chanBEnablePin, chanAEnablePin};
    assign setupPh = psel && !penable;
    // Writes refused until initialisation completes
    assign wrAcc = psel && penable && pwrite && (q.init == INIT_DONE);
    assign wrVout[0] = wrAcc && (paddr == `DCIBS_ADDR_VOUT_A);
    assign wrVout[1] = wrAcc && (paddr == `DCIBS_ADDR_VOUT_B);
    assign usTick = (q.usCnt == 7'(`DCIBS_US_CYCLES - 1));
    assign strapBoot = `DCIBS_STRAP_BASE_MV
        + 16'(chanABootStrapPin) * `DCIBS_STRAP_STEP_MV;

    // ****************************************
    // Enable condition per channel
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_en
            logic usePin;
            logic useSoft;
            logic softOn;
            assign usePin = q.onOff[4 * g + `DCIBS_ONOFF_USE_PIN];
            assign useSoft = q.onOff[4 * g + `DCIBS_ONOFF_USE_SOFT];
            assign softOn = q.onOff[4 * g + `DCIBS_ONOFF_SOFT_ON];
            // Neither source selected means never on
            assign enCond[g] = (!usePin || enPin[g]) && (!useSoft || softOn)
                && (usePin || useSoft);
        end
    endgenerate

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [15:0] diff;
        logic [15:0] step;
        logic [11:0] rdAddr;
        next_q = q;
        diff = 16'h0000;
        step = 16'h0000;
        rdAddr = paddr;
        next_q.usCnt = usTick ? 7'h00 : q.usCnt + 7'h01;
        next_q.scaleEn = (q.voutMax > `DCIBS_SCALE_THRESH_MV);

        // One pass only: nothing but rst returns to INIT_RUN
        if (q.init == INIT_RUN) begin
            next_q.initCnt = q.initCnt + 22'h000001;
            if (q.initCnt == 22'(INIT_CYCLES - 1)) begin
                next_q.init = INIT_DONE;
                next_q.memFail = memSelfTestFail;
                next_q.bootA = strapOverrideSetting ? nonvolatileStoreVoutA
                    : strapBoot;
                next_q.bootB = nonvolatileStoreVoutB;
                for (int i = 0; i < 2; i++) begin
                    next_q.ch[i].senseFault = senseOpen[i] || senseShort[i];
                end
            end
        end

        // Read data and error latched in setup, presented in access
        if (setupPh) begin
            next_q.pslverr = (q.init == INIT_RUN);
            next_q.prdata = 32'h00000000;
            case (rdAddr)
                `DCIBS_ADDR_ONOFF: next_q.prdata = {24'h000000, q.onOff};
                `DCIBS_ADDR_VOUT_A: next_q.prdata = {16'h0000, q.ch[0].target};
                `DCIBS_ADDR_VOUT_B: next_q.prdata = {16'h0000, q.ch[1].target};
                `DCIBS_ADDR_RATE: next_q.prdata = {24'h000000, q.rate};
                `DCIBS_ADDR_VMAX: next_q.prdata = {16'h0000, q.voutMax};
                `DCIBS_ADDR_STATUS: begin
                    next_q.prdata[`DCIBS_ST_INIT] = (q.init == INIT_DONE);
                    next_q.prdata[`DCIBS_ST_MEMFAIL] = q.memFail;
                    next_q.prdata[`DCIBS_ST_SCALE] = q.scaleEn;
                    next_q.prdata[`DCIBS_ST_CH0 +: 8] = {q.ch[0].pg, q.ch[0].pwm,
                        q.ch[0].senseFault, 2'h0, q.ch[0].st};
                    next_q.prdata[`DCIBS_ST_CH1 +: 8] = {q.ch[1].pg, q.ch[1].pwm,
                        q.ch[1].senseFault, 2'h0, q.ch[1].st};
                end
                `DCIBS_ADDR_SETPT: next_q.prdata = {q.ch[1].setpoint, q.ch[0].setpoint};
                default: next_q.pslverr = 1'b1;
            endcase
        end

        if (wrAcc && !q.pslverr) begin
            case (paddr)
                `DCIBS_ADDR_ONOFF: next_q.onOff = pwdata[7:0];
                `DCIBS_ADDR_RATE: next_q.rate = pwdata[7:0];
                `DCIBS_ADDR_VMAX: next_q.voutMax = pwdata[15:0];
                default: next_q.onOff = q.onOff;
            endcase
        end

        // Independent machine per channel
        for (int i = 0; i < 2; i++) begin
            case (q.ch[i].st)
                CH_IDLE: begin
                    next_q.ch[i].pwm = 1'b0;
                    next_q.ch[i].pg = 1'b0;
                    next_q.ch[i].qualCnt = 17'h00000;
                    if (q.init == INIT_DONE && enCond[i] && !q.ch[i].senseFault) begin
                        next_q.ch[i].st = CH_QUAL;
                    end
                end
                CH_QUAL: begin
                    if (!enCond[i]) begin
                        next_q.ch[i].st = CH_IDLE;
                    end else if (!stageInputAboveOn[i] || driverSupplyLowFault[i]) begin
                        // Any dropout restarts the full qualification window
                        next_q.ch[i].qualCnt = 17'h00000;
                    end else if (q.ch[i].qualCnt == 17'(QUAL_CYCLES - 1)) begin
                        next_q.ch[i].st = CH_RAMP;
                        next_q.ch[i].pwm = 1'b1;
                        next_q.ch[i].setpoint = 16'h0000;
                        next_q.ch[i].target = (i == 0) ? q.bootA : q.bootB;
                    end else begin
                        next_q.ch[i].qualCnt = q.ch[i].qualCnt + 17'h00001;
                    end
                end
                CH_RAMP, CH_RUN: begin
                    if (q.ch[i].setpoint < q.ch[i].target) begin
                        diff = q.ch[i].target - q.ch[i].setpoint;
                    end else begin
                        diff = q.ch[i].setpoint - q.ch[i].target;
                    end
                    step = (diff > {8'h00, q.rate}) ? {8'h00, q.rate} : diff;
                    if (usTick) begin
                        if (q.ch[i].setpoint < q.ch[i].target) begin
                            next_q.ch[i].setpoint = q.ch[i].setpoint + step;
                        end else begin
                            next_q.ch[i].setpoint = q.ch[i].setpoint - step;
                        end
                    end
                    if (q.ch[i].st == CH_RAMP && q.ch[i].setpoint == q.ch[i].target) begin
                        next_q.ch[i].st = CH_RUN;
                        next_q.ch[i].pg = 1'b1;
                    end
                    if (q.ch[i].st == CH_RUN) begin
                        // Bus write wins over a same-cycle adaptive command
                        if (wrVout[i] && !q.pslverr) begin
                            next_q.ch[i].target = pwdata[15:0];
                        end else if (avsVoutValid[i]) begin
                            next_q.ch[i].target = avsVout[i];
                        end
                    end
                    if (faultShutdown[i]) begin
                        next_q.ch[i].st = CH_FAULT;
                        next_q.ch[i].pwm = 1'b0;
                        next_q.ch[i].pg = 1'b0;
                    end else if (!enCond[i]) begin
                        next_q.ch[i].st = CH_IDLE;
                        next_q.ch[i].pwm = 1'b0;
                        next_q.ch[i].pg = 1'b0;
                    end
                end
                CH_FAULT: begin
                    next_q.ch[i].pwm = 1'b0;
                    next_q.ch[i].pg = 1'b0;
                    // Restart needs a fresh enable and full qualification
                    if (!enCond[i]) begin
                        next_q.ch[i].st = CH_IDLE;
                    end
                end
                default: next_q.ch[i].st = CH_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.init <= INIT_RUN;
            q.onOff <= `DCIBS_ONOFF_RST;
            q.rate <= `DCIBS_RATE_RST;
            q.voutMax <= `DCIBS_VMAX_RST;
        end else begin
            q <= next_q;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata = q.prdata;
    assign pready = psel && penable;
    assign pslverr = psel && penable && q.pslverr;
    // Modulation pins released until initialisation completes
    assign pwmOen = {2{q.init == INIT_RUN}};
    assign pwmEnable = {q.ch[1].pwm, q.ch[0].pwm};
    assign chanAPowerGood = q.ch[0].pg;
    assign chanBPowerGood = q.ch[1].pg;
    assign setpoint = {q.ch[1].setpoint, q.ch[0].setpoint};
    assign senseScaleEn = q.scaleEn;
    assign initDone = (q.init == INIT_DONE);

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_pg_init_low: assert property (!initDone |-> !chanAPowerGood && !chanBPowerGood)
        else $error("power good high during initialisation");
    a_pwm_release: assert property (!initDone |-> pwmOen == 2'h3 && pwmEnable == 2'h0)
        else $error("modulation pins driven during initialisation");
    a_init_once: assert property (initDone |=> initDone)
        else $error("initialisation restarted");
    a_init_refuse: assert property (!initDone && psel && penable |-> pslverr)
        else $error("bus access accepted during initialisation");
    a_bootb_store: assert property ($rose(initDone) |-> q.bootB == $past(nonvolatileStoreVoutB))
        else $error("channel B boot value not from store");
    a_boota_sel: assert property ($rose(initDone) |-> q.bootA == ($past(strapOverrideSetting)
        ? $past(nonvolatileStoreVoutA) : $past(strapBoot)))
        else $error("channel A boot source wrong");
    a_scale_sel: assert property ($changed(q.voutMax) |=> senseScaleEn ==
        ($past(q.voutMax) > `DCIBS_SCALE_THRESH_MV))
        else $error("sense scaling mismatch");
    a_init_timer: assert property ($rose(initDone) |->
        $past(q.initCnt) == 22'(INIT_CYCLES - 1))
        else $error("initialisation length wrong");
    a_write_drop: assert property (!initDone && psel && penable && pwrite |=>
        $stable(q.onOff) && $stable(q.rate) && $stable(q.voutMax))
        else $error("write taken during initialisation");
    a_memfail_cap: assert property ($rose(initDone) |->
        q.memFail == $past(memSelfTestFail))
        else $error("self-check result not captured");

    generate
        for (g = 0; g < 2; g++) begin : gen_chk
            a_qual_ok: assert property ($rose(pwmEnable[g]) |->
                $past(stageInputAboveOn[g] && !driverSupplyLowFault[g] && enCond[g]))
                else $error("modulation started without qualified supplies");
            a_qual_time: assert property ($rose(pwmEnable[g]) |->
                $past(q.ch[g].qualCnt) == 17'(QUAL_CYCLES - 1))
                else $error("qualification time wrong");
            a_boot_target: assert property ($rose(pwmEnable[g]) |->
                q.ch[g].target == ((g == 0) ? q.bootA : q.bootB) && q.ch[g].setpoint == 16'h0000)
                else $error("start not aimed at boot voltage");
            a_sense_block: assert property (q.ch[g].senseFault |-> !pwmEnable[g])
                else $error("start despite sense fault");
            a_slew_limit: assert property (pwmEnable[g] && $past(pwmEnable[g])
                && $changed(setpoint[g]) |-> $past(usTick) &&
                ((setpoint[g] > $past(setpoint[g])) ? (setpoint[g] - $past(setpoint[g]))
                : ($past(setpoint[g]) - setpoint[g])) <= {8'h00, $past(q.rate)})
                else $error("setpoint step beyond transition rate");
            a_idle_hold: assert property (initDone && q.ch[g].st == CH_IDLE && !enCond[g]
                |=> !pwmEnable[g] ##1 !pwmEnable[g])
                else $error("channel left idle without enable");

            a_idle_init: assert property (!initDone |-> q.ch[g].st == CH_IDLE)
                else $error("channel left idle during initialisation");
            a_enable_drop: assert property (pwmEnable[g] && !enCond[g] |=> !pwmEnable[g])
                else $error("modulation kept without enable");
            a_qual_restart: assert property (q.ch[g].st == CH_QUAL && enCond[g]
                && (!stageInputAboveOn[g] || driverSupplyLowFault[g]) |=>
                q.ch[g].qualCnt == 17'h00000)
                else $error("qualification kept over supply dropout");
            a_mod_state: assert property (pwmEnable[g] |->
                q.ch[g].st inside {CH_RAMP, CH_RUN})
                else $error("modulation outside ramp or run");

            a_fault_stop: assert property (faultShutdown[g] && pwmEnable[g] |=>
                !pwmEnable[g])
                else $error("modulation kept after fault shutdown");
            a_fault_hold: assert property (q.ch[g].st == CH_FAULT |=> !pwmEnable[g])
                else $error("restart without fresh enable");
            a_requal: assert property ($rose(pwmEnable[g]) |->
                $past(q.ch[g].st) == CH_QUAL)
                else $error("start without qualification");

            a_pg_ramp_end: assert property ($rose(q.ch[g].pg) |->
                $past(q.ch[g].st == CH_RAMP && q.ch[g].setpoint == q.ch[g].target))
                else $error("power good before boot level");
            a_pg_mod: assert property (q.ch[g].pg |-> pwmEnable[g])
                else $error("power good without modulation");
            a_avs_take: assert property (q.ch[g].st == CH_RUN && avsVoutValid[g]
                && !wrVout[g] |=> q.ch[g].target == $past(avsVout[g]))
                else $error("adaptive setpoint not taken");
            a_bus_take: assert property (q.ch[g].st == CH_RUN && wrVout[g] && !q.pslverr
                |=> q.ch[g].target == $past(pwdata[15:0]))
                else $error("bus setpoint not taken");
            a_sense_cap: assert property ($rose(initDone) |->
                q.ch[g].senseFault == $past(senseOpen[g] || senseShort[g]))
                else $error("sense pair result not captured");

            c_avs_take: cover property (avsVoutValid[g] && q.ch[g].st == CH_RUN);
            c_power_good: cover property ($rose(q.ch[g].pg));
            c_fault_requal: cover property (q.ch[g].st == CH_FAULT ##[1:1000] q.ch[g].st == CH_QUAL);
        end
    endgenerate
    c_override: cover property ($rose(initDone) && $past(strapOverrideSetting));
    c_sense_fault: cover property ($rose(q.ch[0].senseFault));

endmodule // dcibs_top

`default_nettype wire

//--- inc/dcibs_consts.svh
`ifndef DCIBS_CONSTS_SVH
`define DCIBS_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
`define DCIBS_CLK_MHZ 100
`define DCIBS_INIT_TIME_US 20000
`define DCIBS_QUAL_TIME_US 750
`define DCIBS_QUAL_MAX_US 1000
`define DCIBS_INIT_CYCLES (`DCIBS_INIT_TIME_US * `DCIBS_CLK_MHZ)
`define DCIBS_QUAL_CYCLES (`DCIBS_QUAL_TIME_US * `DCIBS_CLK_MHZ)
`define DCIBS_US_CYCLES (`DCIBS_CLK_MHZ)

// ****************************************
// Register offsets
// ****************************************
`define DCIBS_ADDR_ONOFF 12'h000
`define DCIBS_ADDR_VOUT_A 12'h004
`define DCIBS_ADDR_VOUT_B 12'h008
`define DCIBS_ADDR_RATE 12'h00c
`define DCIBS_ADDR_VMAX 12'h010
`define DCIBS_ADDR_STATUS 12'h014
`define DCIBS_ADDR_SETPT 12'h018

// ****************************************
// Fields and reset values
// ****************************************
`define DCIBS_ONOFF_USE_PIN 0
`define DCIBS_ONOFF_USE_SOFT 1
`define DCIBS_ONOFF_SOFT_ON 2
`define DCIBS_ONOFF_RST 8'h11
`define DCIBS_RATE_RST 8'h01
`define DCIBS_VMAX_RST 16'h05dc
`define DCIBS_SCALE_THRESH_MV 16'h074e
`define DCIBS_STRAP_BASE_MV 16'h00fa
`define DCIBS_STRAP_STEP_MV 16'h0005
`define DCIBS_ST_INIT 0
`define DCIBS_ST_MEMFAIL 1
`define DCIBS_ST_SCALE 2
`define DCIBS_ST_CH0 4
`define DCIBS_ST_CH1 12

`endif

//--- inc/dcibs_pkg.sv
package dcibs_pkg;

    typedef enum logic {
        INIT_RUN = 1'b0,
        INIT_DONE = 1'b1
    } dcibs_init_e;

    // Gray along idle, qualify, ramp, run
    typedef enum logic [2:0] {
        CH_IDLE = 3'h0,
        CH_QUAL = 3'h1,
        CH_RAMP = 3'h3,
        CH_RUN = 3'h2,
        CH_FAULT = 3'h6
    } dcibs_chst_e;

    typedef struct packed {
        dcibs_chst_e st;
        logic [16:0] qualCnt;
        logic [15:0] target;
        logic [15:0] setpoint;
        logic senseFault;
        logic pwm;
        logic pg;
    } dcibs_chan_s;

    typedef struct packed {
        dcibs_init_e init;
        logic [21:0] initCnt;
        logic [6:0] usCnt;
        logic [7:0] onOff;
        logic [7:0] rate;
        logic [15:0] voutMax;
        logic scaleEn;
        logic memFail;
        logic [15:0] bootA;
        logic [15:0] bootB;
        dcibs_chan_s [1:0] ch;
        logic [31:0] prdata;
        logic pslverr;
    } dcibs_state_s;

endpackage

//--- tb/dcibs_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************
// Host driving the channel enable pins
// ****************************************
module dcibs_host_model
    import dcibs_pkg::*;
#(
    parameter int SETTLE = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host requests
    input wire logic supplyOk,
    input wire logic [1:0] enReq,
    // Enable pins
    output logic chanAEnablePin,
    output logic chanBEnablePin
);
    int settleCnt;

    // Enables are held back until the supplies have settled
    always_ff @(posedge clk) begin
        if (rst || !supplyOk) begin
            settleCnt <= 0;
        end else if (settleCnt < SETTLE) begin
            settleCnt <= settleCnt + 1;
        end
        chanAEnablePin <= enReq[0] && settleCnt == SETTLE && !rst;
        chanBEnablePin <= enReq[1] && settleCnt == SETTLE && !rst;
    end
endmodule // dcibs_host_model

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "dcibs_consts.svh"

module tb import dcibs_pkg::*;;
    localparam int INIT = 50;
    localparam int QUAL = 20;
    localparam int QMAX = QUAL * 4 / 3 + 1;
    localparam logic [15:0] BOOTA = `DCIBS_STRAP_BASE_MV + `DCIBS_STRAP_STEP_MV * 16'h000a;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er;
    logic memSelfTestFail = 1'b0, strapOverrideSetting = 1'b0, hostSupplyOk = 1'b1;
    logic [7:0] chanABootStrapPin = 8'h0a;
    logic [15:0] nvA = 16'h0384, nvB = 16'h0258;
    logic [1:0] senseOpen = 2'h0, senseShort = 2'h0, stageInputAboveOn = 2'h3;
    logic [1:0] driverSupplyLowFault = 2'h0, faultShutdown = 2'h0, avsVoutValid = 2'h0;
    logic [1:0] enReq = 2'h0, pwmEnable, pwmOen;
    logic [1:0][15:0] avsVout = 32'h0, setpoint;
    logic chanAEnablePin, chanBEnablePin, chanAPowerGood, chanBPowerGood, senseScaleEn, initDone;
    wire logic [1:0] pgs;
    int errCount = 0, samplesChecked = 0, waited;

    assign pgs = {chanBPowerGood, chanAPowerGood};
    always #5 clk = ~clk;

    dcibs_top #(.INIT_CYCLES(INIT), .QUAL_CYCLES(QUAL)) i_dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .memSelfTestFail(memSelfTestFail), .chanABootStrapPin(chanABootStrapPin),
        .strapOverrideSetting(strapOverrideSetting), .nonvolatileStoreVoutA(nvA),
        .nonvolatileStoreVoutB(nvB), .senseOpen(senseOpen), .senseShort(senseShort),
        .chanAEnablePin(chanAEnablePin), .chanBEnablePin(chanBEnablePin),
        .stageInputAboveOn(stageInputAboveOn), .driverSupplyLowFault(driverSupplyLowFault),
        .faultShutdown(faultShutdown), .avsVoutValid(avsVoutValid), .avsVout(avsVout),
        .pwmEnable(pwmEnable), .pwmOen(pwmOen), .chanAPowerGood(chanAPowerGood),
        .chanBPowerGood(chanBPowerGood), .setpoint(setpoint), .senseScaleEn(senseScaleEn),
        .initDone(initDone));

    dcibs_host_model #(.SETTLE(8)) i_host (.clk(clk), .rst(rst), .supplyOk(hostSupplyOk),
        .enReq(enReq), .chanAEnablePin(chanAEnablePin), .chanBEnablePin(chanBEnablePin));

    // ****************************************
    // Checking and bus tasks
    // ****************************************
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", errCount, samplesChecked);
        if (errCount == 0 && samplesChecked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samplesChecked++;
        if (got !== exp) begin
            errCount++;
            $display("BAD t=%0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic timeout(input string what);
        errCount++;
        $display("BAD t=%0t no response: %s", $time, what);
        end_of_test();
    endtask

    // Waits for the ready answer; no wait-state count is assumed
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) timeout("bus");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chkReg(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "register read");
    endtask

    function automatic logic hit(input int what, input int ch, input logic [15:0] v);
        case (what)
            0: return pwmEnable[ch] === 1'b1;
            1: return setpoint[ch] === v;
            2: return pgs[ch] === 1'b1;
            3: return initDone === 1'b1;
            default: return chanAEnablePin === 1'b1;
        endcase
    endfunction

    task automatic waitFor(input int what, input int ch, input logic [15:0] v);
        waited = 0;
        while (!hit(what, ch, v) && waited < 5000) begin
            @(negedge clk);
            waited++;
        end
        if (waited >= 5000) timeout("channel event");
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(32'(pwmOen), 32'h3, "pins released in init");
        chk(32'(pgs), 32'h0, "power good held low");
        apb(1'b0, `DCIBS_ADDR_STATUS, 32'h0);
        chk(32'(er), 32'h1, "access during init");
        apb(1'b1, `DCIBS_ADDR_RATE, 32'h55);
        waitFor(3, 0, 16'h0000);
        chk(32'(waited <= INIT), 32'h1, "init length");
        chkReg(`DCIBS_ADDR_ONOFF, 32'h11);
        chkReg(`DCIBS_ADDR_RATE, 32'h1);
        chkReg(`DCIBS_ADDR_VMAX, 32'h5dc);
        apb(1'b0, 12'h020, 32'h0);
        chk(32'(er), 32'h1, "unmapped address");
        apb(1'b0, `DCIBS_ADDR_STATUS, 32'h0);
        chk(32'(rd[2:0]), 32'h1, "status after init");
        apb(1'b1, `DCIBS_ADDR_VMAX, 32'h74e);
        repeat (2) @(negedge clk);
        chk(32'(senseScaleEn), 32'h0, "scaling at 1870 mV");
        apb(1'b1, `DCIBS_ADDR_VMAX, 32'h74f);
        repeat (2) @(negedge clk);
        chk(32'(senseScaleEn), 32'h1, "scaling above 1870 mV");
        apb(1'b1, `DCIBS_ADDR_RATE, 32'h64);
        @(posedge clk);
        enReq <= 2'h1;
        waitFor(4, 0, 16'h0000);
        waitFor(0, 0, 16'h0000);
        chk(32'(waited >= QUAL && waited <= QMAX), 32'h1, "qualify time");
        waitFor(2, 0, 16'h0000);
        chk(32'(setpoint[0]), 32'(BOOTA), "boot A from strap");
        @(posedge clk);
        enReq <= 2'h3;
        waitFor(2, 1, 16'h0000);
        chk(32'(setpoint[1]), 32'(nvB), "boot B from store");
        apb(1'b1, `DCIBS_ADDR_RATE, 32'h14);
        apb(1'b1, `DCIBS_ADDR_VOUT_A, 32'h190);
        waitFor(1, 0, 16'h0190);
        chk(32'(waited >= 400 && waited <= 520), 32'h1, "ramp time");
        @(posedge clk);
        avsVout[1] <= 16'h02bc;
        avsVoutValid <= 2'h2;
        @(posedge clk);
        avsVoutValid <= 2'h0;
        waitFor(1, 1, 16'h02bc);
        chk(32'(setpoint[1]), 32'h2bc, "adaptive setpoint");
        @(posedge clk);
        faultShutdown <= 2'h1;
        @(posedge clk);
        faultShutdown <= 2'h0;
        repeat (2) @(negedge clk);
        chk(32'(pwmEnable), 32'h2, "fault stops A only");
        @(posedge clk);
        stageInputAboveOn <= 2'h2;
        enReq <= 2'h2;
        repeat (4) @(posedge clk);
        enReq <= 2'h3;
        repeat (3 * QUAL) @(negedge clk);
        chk(32'(pwmEnable[0]), 32'h0, "input supply low");
        @(posedge clk);
        stageInputAboveOn <= 2'h3;
        driverSupplyLowFault <= 2'h1;
        repeat (3 * QUAL) @(negedge clk);
        chk(32'(pwmEnable[0]), 32'h0, "driver supply low");
        @(posedge clk);
        driverSupplyLowFault <= 2'h0;
        waitFor(0, 0, 16'h0000);
        chk(32'(waited >= QUAL && waited <= QMAX), 32'h1, "requalify time");
        waitFor(2, 0, 16'h0000);
        chk(32'(setpoint[0]), 32'(BOOTA), "reboot to boot level");
        chk(32'(initDone), 32'h1, "init ran once");
        // Power cycle with store boot for A and an open sense pair on B
        @(posedge clk);
        rst <= 1'b1;
        strapOverrideSetting <= 1'b1;
        senseOpen <= 2'h2;
        memSelfTestFail <= 1'b1;
        enReq <= 2'h2;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk(32'(initDone), 32'h0, "init reruns after power cycle");
        chk(32'(pwmOen), 32'h3, "pins released again");
        waitFor(3, 0, 16'h0000);
        apb(1'b0, `DCIBS_ADDR_STATUS, 32'h0);
        chk(32'(rd[`DCIBS_ST_CH1 + 5]), 32'h1, "sense fault on B");
        chk(32'(rd[`DCIBS_ST_MEMFAIL]), 32'h1, "self-check failure");
        apb(1'b1, `DCIBS_ADDR_RATE, 32'h64);
        apb(1'b1, `DCIBS_ADDR_ONOFF, 32'h16);
        waitFor(2, 0, 16'h0000);
        chk(32'(setpoint[0]), 32'(nvA), "soft-on boot A from store");
        chk(32'(pwmEnable[1]), 32'h0, "B blocked by open sense");
        chkReg(`DCIBS_ADDR_SETPT, 32'(nvA));
        end_of_test();
    end

    // Hang guard
    initial begin
        #1000000;
        timeout("whole run");
    end
endmodule // tb

`default_nettype wire
